//--- rtl/clr_regs.vh
`ifndef CLR_REGS_VH
`define CLR_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CLR_ADDR_W 8
`define CLR_OFF_RPT 8'h75
`define CLR_OFF_CTRL 8'h77
`define CLR_OFF_FCLR 8'h78

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CLR_RST_RPT 8'hF8
`define CLR_RST_CTRL 8'h00
`define CLR_RST_FCLR 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CLR_LVL_HI 4
`define CLR_LVL_LO 3
`define CLR_FUNC_EN 2
`define CLR_WARN_EN 1
`define CLR_FLT_EN 0
`define CLR_FCLR_BIT 7
`define CLR_FCLR_RSV_HI 6
`define CLR_CTRL_RSV_HI 7
`define CLR_CTRL_RSV_LO 5
`define CLR_FLT_HOLD 7
`define CLR_WARN_HOLD 6
`define CLR_WARN_SUP 1
`define CLR_FLT_SUP 0

// ----------------------------------------
// Level codes
// ----------------------------------------
`define CLR_LVL_80 2'h0
`define CLR_LVL_40 2'h1
`define CLR_LVL_60 2'h2
`define CLR_PCT_80 7'h50
`define CLR_PCT_60 7'h3C
`define CLR_PCT_40 7'h28

// ----------------------------------------
// Synchroniser, latch and read port
// ----------------------------------------
`define CLR_SYNC_STAGES 2
`define CLR_RST_SYNC 1'b0
`define CLR_RST_LATCH 1'b0
`define CLR_FCLR_RSV_LO 0
`define CLR_RST_RDATA 8'h00
`define CLR_RD_UNMAPPED 8'h00

`endif

//--- rtl/clr_regs.v
// Overview of operation
// - Level field: 00=80%, 10=60%, 01=40%
// - Bit 2 enables per-cycle limiting
// - Bit 1 enables limit warning generation
// - Bit 0 enables limit fault generation
// - Writing fault-clear bit 7 clears faults
// - Reserved bits read-write, no effect
// - Fault hold enable resets 1, latches fault
// - Warning hold enable resets 1, latches warning
// - Warning suppress bit masks warning report
// - Fault suppress bit masks fault report
`timescale 1ns/100ps
`include "clr_regs.vh"

module clr_regs
(
	input wire clk_i,
	input wire reset_i,
	input wire wr_en_i,
	input wire rd_en_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire limit_hit_i,
	input wire limit_warn_i,
	output reg [7:0] rdata_o,
	output reg rvalid_o,
	output reg limit_function_enable_o,
	output reg [6:0] limit_level_pct_o,
	output reg analog_fault_clear_o,
	output reg limit_warning_o,
	output reg limit_fault_o
);

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
// Limit events come straight off the analog comparators
wire hit_s;
wire warn_s;

clr_sync i_hit_sync
(
	.clk_i(clk_i),
	.reset_i(reset_i),
	.async_i(limit_hit_i),
	.sync_o(hit_s)
);

clr_sync i_warn_sync
(
	.clk_i(clk_i),
	.reset_i(reset_i),
	.async_i(limit_warn_i),
	.sync_o(warn_s)
);

// ----------------------------------------
// Register file
// ----------------------------------------
reg [7:0] ctrl_r;
reg [7:0] fclr_r;
reg [7:0] rpt_r;
wire wr_ctrl = wr_en_i && (addr_i == `CLR_OFF_CTRL);
wire wr_fclr = wr_en_i && (addr_i == `CLR_OFF_FCLR);
wire wr_rpt = wr_en_i && (addr_i == `CLR_OFF_RPT);
wire clear_req = wr_fclr && wdata_i[`CLR_FCLR_BIT];

always @(posedge clk_i or posedge reset_i)
begin
	if (reset_i)
	begin
		ctrl_r <= `CLR_RST_CTRL;
		fclr_r <= `CLR_RST_FCLR;
		rpt_r <= `CLR_RST_RPT;
	end
	else
	begin
		if (wr_ctrl)
			ctrl_r <= wdata_i;
		if (wr_fclr)
			fclr_r <= {1'b0, wdata_i[`CLR_FCLR_RSV_HI:`CLR_FCLR_RSV_LO]};
		if (wr_rpt)
			rpt_r <= wdata_i;
	end
end

// Strobe bit never stored, so it reads back as zero
always @(posedge clk_i or posedge reset_i)
begin
	if (reset_i)
	begin
		rdata_o <= `CLR_RST_RDATA;
		rvalid_o <= 1'b0;
	end
	else
	begin
		rvalid_o <= rd_en_i;
		if (rd_en_i)
		begin
			case (addr_i)
				`CLR_OFF_CTRL: rdata_o <= ctrl_r;
				`CLR_OFF_FCLR: rdata_o <= fclr_r;
				`CLR_OFF_RPT: rdata_o <= rpt_r;
				default: rdata_o <= `CLR_RD_UNMAPPED;
			endcase
		end
	end
end

// ----------------------------------------
// Limit control and fault state
// ----------------------------------------
wire [1:0] lvl = ctrl_r[`CLR_LVL_HI:`CLR_LVL_LO];
reg [6:0] pct_nxt;
always @*
begin
	case (lvl)
		`CLR_LVL_80: pct_nxt = `CLR_PCT_80;
		`CLR_LVL_60: pct_nxt = `CLR_PCT_60;
		`CLR_LVL_40: pct_nxt = `CLR_PCT_40;
		default: pct_nxt = `CLR_PCT_80;
	endcase
end

wire en = ctrl_r[`CLR_FUNC_EN];
wire flt_ev = en && ctrl_r[`CLR_FLT_EN] && hit_s;
wire wrn_ev = en && ctrl_r[`CLR_WARN_EN] && warn_s;
wire flt_nxt;
wire wrn_nxt;

// Set beats clear: an event in the clear cycle stays latched
clr_evt_latch i_flt_latch
(
	.clk_i(clk_i),
	.reset_i(reset_i),
	.event_i(flt_ev),
	.hold_en_i(rpt_r[`CLR_FLT_HOLD]),
	.clear_i(clear_req),
	.held_nxt_o(flt_nxt)
);

clr_evt_latch i_wrn_latch
(
	.clk_i(clk_i),
	.reset_i(reset_i),
	.event_i(wrn_ev),
	.hold_en_i(rpt_r[`CLR_WARN_HOLD]),
	.clear_i(clear_req),
	.held_nxt_o(wrn_nxt)
);

always @(posedge clk_i or posedge reset_i)
begin
	if (reset_i)
	begin
		limit_function_enable_o <= 1'b0;
		limit_level_pct_o <= `CLR_PCT_80;
		analog_fault_clear_o <= 1'b0;
		limit_warning_o <= 1'b0;
		limit_fault_o <= 1'b0;
	end
	else
	begin
		limit_function_enable_o <= en;
		limit_level_pct_o <= pct_nxt;
		analog_fault_clear_o <= clear_req;
		limit_warning_o <= wrn_nxt && !rpt_r[`CLR_WARN_SUP];
		limit_fault_o <= flt_nxt && !rpt_r[`CLR_FLT_SUP];
	end
end

endmodule // clr_regs

// ----------------------------------------
// Synchroniser chain
// ----------------------------------------
module clr_sync
#(
	parameter STAGES = `CLR_SYNC_STAGES
)
(
	input wire clk_i,
	input wire reset_i,
	input wire async_i,
	output wire sync_o
);

// Only the last stage is read: the first may be metastable
reg [STAGES-1:0] chain_r;

always @(posedge clk_i or posedge reset_i)
begin
	if (reset_i)
		chain_r <= {STAGES{`CLR_RST_SYNC}};
	else
		chain_r <= {chain_r[STAGES-2:0], async_i};
end

assign sync_o = chain_r[STAGES-1];

endmodule // clr_sync

// ----------------------------------------
// Event latch with hold enable
// ----------------------------------------
module clr_evt_latch
(
	input wire clk_i,
	input wire reset_i,
	input wire event_i,
	input wire hold_en_i,
	input wire clear_i,
	output wire held_nxt_o
);

reg held_r;

// With hold off the report simply tracks the live event
assign held_nxt_o = event_i || (hold_en_i && held_r && !clear_i);

always @(posedge clk_i or posedge reset_i)
begin
	if (reset_i)
		held_r <= `CLR_RST_LATCH;
	else
		held_r <= held_nxt_o;
end

endmodule // clr_evt_latch

//--- tb/clr_regs_props.sv
`timescale 1ns/100ps
module clr_props
(
	input wire clk_i,
	reset_i,
	wr_en_i,
	rd_en_i,
	limit_hit_i,
	limit_warn_i,
	rvalid_o,
	limit_function_enable_o,
	analog_fault_clear_o,
	limit_warning_o,
	limit_fault_o,
	input wire [7:0] addr_i,
	wdata_i,
	rdata_o,
	input wire [6:0] limit_level_pct_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (reset_i);
wire wc = wr_en_i && addr_i == 8'h77;
wire wf = wr_en_i && addr_i == 8'h78;
chk_rd_valid: assert property (rvalid_o == $past(rd_en_i)) else $error("rv");
chk_en_follow: assert property (wc |-> ##2
	limit_function_enable_o == $past(wdata_i[2], 2)) else $error("en");
chk_lvl_map: assert property (wc && wdata_i[4:3] == 2'h2
	|-> ##2 limit_level_pct_o == 7'h3C) else $error("lvl");
chk_clr_pulse: assert property (wf && wdata_i[7] |-> ##1 analog_fault_clear_o) else $error("c");
chk_clr_once: assert property (analog_fault_clear_o |-> $past(wf && wdata_i[7])) else $error("c1");
chk_clr_rd: assert property (rd_en_i && addr_i == 8'h78 |=> !rdata_o[7]) else $error("rd");
chk_flt_cause: assert property ($rose(limit_fault_o) |-> $past(limit_hit_i, 3)) else $error("f");
chk_wrn_cause: assert property ($rose(limit_warning_o) |-> $past(limit_warn_i, 3)) else $error("w");
endmodule // clr_props
bind clr_regs clr_props i_chk(.*);

//--- tb/clr_host.sv
`timescale 1ns/100ps
module clr_host
(
	input wire clk_i,
	input wire [7:0] rdata_i,
	output reg we_o = 0,
	re_o = 0,
	output reg [7:0] a_o = 0,
	d_o = 0
);
// Inverse on release: a stale bus must not pass
task xf(input w, input [7:0] a, dw, output [7:0] d);
begin
	@(negedge clk_i);
	{we_o, re_o, a_o, d_o} = {w, !w, a, dw};
	@(negedge clk_i);
	{we_o, re_o, a_o, d_o} = {2'h0, ~a, ~dw};
	d = rdata_i;
end
endtask
endmodule // clr_host

//--- tb/clr_tb.sv
`timescale 1ns/100ps
module current_limit_ctrl_regs_tb_top;
reg clk_i = 0, reset_i = 1, limit_hit_i = 0, limit_warn_i = 0;
wire wr_en_i, rd_en_i, rvalid_o, limit_function_enable_o;
wire analog_fault_clear_o, limit_warning_o, limit_fault_o;
wire [7:0] addr_i, wdata_i, rdata_o;
wire [6:0] limit_level_pct_o;
integer n_errors = 0, compares = 0, seed = 32'h2D36, i;
reg [7:0] v, d;
clr_regs i_dut(.clk_i(clk_i), .reset_i(reset_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .limit_hit_i(limit_hit_i), .limit_warn_i(limit_warn_i),
	.rdata_o(rdata_o), .rvalid_o(rvalid_o), .limit_function_enable_o(limit_function_enable_o),
	.limit_level_pct_o(limit_level_pct_o), .analog_fault_clear_o(analog_fault_clear_o),
	.limit_warning_o(limit_warning_o), .limit_fault_o(limit_fault_o));
clr_host i_host(.clk_i(clk_i), .rdata_i(rdata_o), .we_o(wr_en_i), .re_o(rd_en_i),
	.a_o(addr_i), .d_o(wdata_i));
initial forever #5 clk_i = ~clk_i;
initial
begin
	#50000 n_errors++;
	complete_run;
end
task complete_run;
	if (n_errors == 0 && compares > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask
task chk(input string n, input [7:0] e, s);
begin
	compares++;
	if (e !== s)
	begin
		n_errors++;
		$display("[ERR] %s exp %h got %h", n, e, s);
	end
end
endtask
function [7:0] pct(input [1:0] c);
	pct = c == 2'h2 ? 8'h3C : c == 2'h1 ? 8'h28 : 8'h50;
endfunction
task ev(input [7:0] c, r, input [1:0] e);
begin
	i_host.xf(1, 8'h77, c, d);
	i_host.xf(1, 8'h75, r, d);
	{limit_hit_i, limit_warn_i} = 2'h3;
	repeat (5) @(negedge clk_i);
	chk("ev", e, {limit_fault_o, limit_warning_o});
	{limit_hit_i, limit_warn_i} = 2'h0;
	repeat (5) @(negedge clk_i);
	chk("hold", e & r[7:6], {limit_fault_o, limit_warning_o});
	i_host.xf(1, 8'h78, 8'h80, d);
	chk("stb", 1, analog_fault_clear_o);
	repeat (3) @(negedge clk_i);
	chk("clr", 0, {limit_fault_o, limit_warning_o});
	chk("stb0", 0, analog_fault_clear_o);
end
endtask
initial
begin
	repeat (3) @(negedge clk_i);
	reset_i = 0;
	chk("pct", 8'h50, limit_level_pct_o);
	i_host.xf(0, 8'h75, 0, d);
	chk("rv", 1, rvalid_o);
	chk("rpt", 8'hF8, d);
	i_host.xf(0, 8'h77, 0, d);
	chk("ctl", 8'h00, d);
	i_host.xf(0, 8'h76, 0, d);
	chk("unm", 8'h00, d);
	for (i = 0; i < 12; i++)
	begin
		v = $random(seed);
		i_host.xf(1, 8'h77, v, d);
		i_host.xf(0, 8'h77, 0, d);
		chk("ctl", v, d);
		chk("pct", pct(v[4:3]), limit_level_pct_o);
		chk("en", v[2], limit_function_enable_o);
	end
	v = $random(seed) & 8'h7F;
	i_host.xf(1, 8'h78, v, d);
	chk("nclr", 0, analog_fault_clear_o);
	i_host.xf(0, 8'h78, 0, d);
	chk("fclr", v, d);
	ev(8'h05, 8'hF8, 2'h2);
	ev(8'h06, 8'hF8, 2'h1);
	ev(8'h03, 8'hF8, 2'h0);
	ev(8'h07, 8'hFB, 2'h0);
	ev(8'h07, 8'h38, 2'h3);
	// Event still present across a clear: set must win
	i_host.xf(1, 8'h77, 8'h05, d);
	i_host.xf(1, 8'h75, 8'h80, d);
	limit_hit_i = 1;
	repeat (5) @(negedge clk_i);
	i_host.xf(1, 8'h78, 8'h80, d);
	chk("setw", 1, limit_fault_o);
	limit_hit_i = 0;
	repeat (5) @(negedge clk_i);
	chk("held", 1, limit_fault_o);
	i_host.xf(1, 8'h78, 8'h80, d);
	chk("freed", 0, limit_fault_o);
	// Reset in mid-run must restore the control and report registers
	i_host.xf(1, 8'h77, 8'h1F, d);
	i_host.xf(0, 8'h77, 0, d);
	chk("en", 1, limit_function_enable_o);
	reset_i = 1;
	repeat (2) @(negedge clk_i);
	reset_i = 0;
	chk("pct", 8'h50, limit_level_pct_o);
	chk("en", 0, limit_function_enable_o);
	i_host.xf(0, 8'h77, 0, d);
	chk("ctl", 8'h00, d);
	i_host.xf(0, 8'h75, 0, d);
	chk("rpt", 8'hF8, d);
	complete_run;
end
endmodule // current_limit_ctrl_regs_tb_top
